// ---- rtl/ufc_pkg.sv ----
// package for the usb function interrupt and endpoint 0 control block
// assumes a single system clock and an indirect index/data register pair
package ufc_pkg;

    // ------------------------------------------------------------
    // indirect register indices
    // ------------------------------------------------------------
    localparam logic [7:0] UFC_ADDR_IN_FLAGS  = 8'h02;
    localparam logic [7:0] UFC_ADDR_OUT_FLAGS = 8'h04;
    localparam logic [7:0] UFC_ADDR_FLAGS    = 8'h06;
    localparam logic [7:0] UFC_ADDR_IN_IE    = 8'h07;
    localparam logic [7:0] UFC_ADDR_OUT_IE   = 8'h09;
    localparam logic [7:0] UFC_ADDR_CMN_IE   = 8'h0B;
    localparam logic [7:0] UFC_ADDR_EP0_CSR  = 8'h11;
    localparam logic [7:0] UFC_ADDR_EP0_CNT  = 8'h16;
    localparam logic [7:0] UFC_ADDR_EP_EN    = 8'h1E;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] UFC_RST_IN_IE  = 4'hF;
    localparam logic [3:0] UFC_RST_OUT_IE = 4'hE;
    localparam logic [3:0] UFC_RST_CMN_IE = 4'h6;
    localparam logic [3:0] UFC_RST_EP_EN  = 4'hF;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int UFC_CF_SUSPEND = 0;
    localparam int UFC_CF_RESUME  = 1;
    localparam int UFC_CF_RESET   = 2;
    localparam int UFC_CF_SOF     = 3;
    localparam int UFC_CSR_RXRDY    = 0;
    localparam int UFC_CSR_DATA_PHASE_DONE  = 3;
    localparam int UFC_CSR_SETUPEND = 4;
    localparam int UFC_CSR_SRXRDY   = 6;
    localparam int UFC_CSR_SSETUP   = 7;
    localparam int UFC_CNT_W        = 7;

endpackage : ufc_pkg

// ---- rtl/ufc_core.sv ----
// interrupt flags, enables and endpoint 0 control of a usb function
// assumes bus events arrive as one-cycle pulses synchronous to clock
// Function
// - reset signalling sets bus reset flag
// - resume sets flag only while suspended
// - suspend sets flag only when detection enabled
// - reading common flags clears all of them
// - in/ep0 interrupt enables, reset to one
// - out interrupt enables bits 3:1, bit0 zero
// - common enables reset pattern 0,1,1,0
// - setup end set on early transaction end
// - serviced setup end write clears setup end
// - rx ready sets, serviced write clears
// - seven bit receive byte count readable
// - disabled endpoints 1-3 give no handshake
// - access via index and data registers
// - suspend mode entered only when detection enabled
`timescale 1ns/10ps
`default_nettype none

module ufc_core
    import ufc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       idx_wr,
    input  wire logic       data_wr,
    input  wire logic       data_rd,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    input  wire logic       suspend_detect_enable,
    input  wire logic       bus_reset_seen,
    input  wire logic       bus_resume_seen,
    input  wire logic       bus_suspend_seen,
    input  wire logic       frame_start_seen,
    input  wire logic       ctrl_end_seen,
    input  wire logic       data_phase_clear,
    input  wire logic       rx_packet_in,
    input  wire logic [6:0] rx_count_in,
    input  wire logic [3:0] in_ep_event,
    input  wire logic [3:1] out_ep_event,
    input  wire logic [3:1] hs_request,
    output logic      [3:1] hs_allow,
    output logic            suspended,
    output logic            irq
);

    // ------------------------------------------------------------
    // register file state
    // ------------------------------------------------------------
    logic [7:0] index_q;
    logic [3:0] cmn_flags_q;
    logic [3:0] in_flags_q;
    logic [3:1] out_flags_q;
    logic [3:0] in_ie_q;
    logic [3:1] out_ie_q;
    logic [3:0] cmn_ie_q;
    logic [3:1] ep_en_q;
    logic       rx_ready_q;
    logic       setup_end_q;
    logic       data_end_q;
    logic [UFC_CNT_W-1:0] rx_count_q;
    logic       rd_flags;
    logic       wr_csr;
    logic [7:0] rdata_d;

    assign rd_flags = data_rd && (index_q == UFC_ADDR_FLAGS);
    assign wr_csr   = data_wr && (index_q == UFC_ADDR_EP0_CSR);

    // ------------------------------------------------------------
    // indirect index register
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            index_q <= 8'h00;
        end else if (idx_wr) begin
            index_q <= wdata;
        end
    end

    a_index_load: assert property (@(posedge clock) disable iff (rst)
        idx_wr |=> (index_q == $past(wdata)))
        else $error("index register not loaded");

    // ------------------------------------------------------------
    // suspend mode
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            suspended <= 1'b0;
        end else if (bus_suspend_seen && suspend_detect_enable) begin
            suspended <= 1'b1;
        end else if (bus_resume_seen || bus_reset_seen) begin
            suspended <= 1'b0;
        end
    end

    a_suspend_enter: assert property (@(posedge clock) disable iff (rst)
        (bus_suspend_seen && suspend_detect_enable) |=> suspended)
        else $error("suspend mode not entered");

    a_suspend_ignored: assert property (@(posedge clock) disable iff (rst)
        (!suspended && !(bus_suspend_seen && suspend_detect_enable)) |=> !suspended)
        else $error("suspend mode entered without enabled detection");

    // ------------------------------------------------------------
    // event flags, set wins over clear-on-read
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cmn_flags_q <= 4'h0;
        end else begin
            cmn_flags_q <= (rd_flags ? 4'h0 : cmn_flags_q)
                | {frame_start_seen,
                   bus_reset_seen,
                   bus_resume_seen && suspended,
                   bus_suspend_seen && suspend_detect_enable};
        end
    end

    a_resume_flag_set: assert property (@(posedge clock) disable iff (rst)
        (bus_resume_seen && suspended) |=> cmn_flags_q[UFC_CF_RESUME])
        else $error("resume flag not set while suspended");

    a_suspend_flag_set: assert property (@(posedge clock) disable iff (rst)
        (bus_suspend_seen && suspend_detect_enable) |=> cmn_flags_q[UFC_CF_SUSPEND])
        else $error("suspend flag not set");

    a_sof_flag_set: assert property (@(posedge clock) disable iff (rst)
        frame_start_seen |=> cmn_flags_q[UFC_CF_SOF])
        else $error("frame start flag not set");

    // endpoint flags also clear when their own register is read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            in_flags_q  <= 4'h0;
            out_flags_q <= 3'h0;
        end else begin
            in_flags_q <= ((data_rd && index_q == UFC_ADDR_IN_FLAGS) ? 4'h0 : in_flags_q)
                | in_ep_event | {3'h0, rx_packet_in};
            out_flags_q <= ((data_rd && index_q == UFC_ADDR_OUT_FLAGS) ? 3'h0 : out_flags_q)
                | out_ep_event;
        end
    end

    // ------------------------------------------------------------
    // enable registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            in_ie_q  <= UFC_RST_IN_IE;
            out_ie_q <= UFC_RST_OUT_IE[3:1];
            cmn_ie_q <= UFC_RST_CMN_IE;
            ep_en_q  <= UFC_RST_EP_EN[3:1];
        end else if (data_wr) begin
            unique case (index_q)
                UFC_ADDR_IN_IE:  in_ie_q  <= wdata[3:0];
                UFC_ADDR_OUT_IE: out_ie_q <= wdata[3:1];
                UFC_ADDR_CMN_IE: cmn_ie_q <= wdata[3:0];
                UFC_ADDR_EP_EN:  ep_en_q  <= wdata[3:1];
                default: ;
            endcase
        end
    end

    a_in_ie_write: assert property (@(posedge clock) disable iff (rst)
        (data_wr && index_q == UFC_ADDR_IN_IE) |=> (in_ie_q == $past(wdata[3:0])))
        else $error("in endpoint enables not written");

    a_out_ie_write: assert property (@(posedge clock) disable iff (rst)
        (data_wr && index_q == UFC_ADDR_OUT_IE) |=> (out_ie_q == $past(wdata[3:1])))
        else $error("out endpoint enables not written");

    a_cmn_ie_write: assert property (@(posedge clock) disable iff (rst)
        (data_wr && index_q == UFC_ADDR_CMN_IE) |=> (cmn_ie_q == $past(wdata[3:0])))
        else $error("common enables not written");

    // ------------------------------------------------------------
    // endpoint 0 control
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_end_q <= 1'b0;
        end else if (wr_csr && wdata[UFC_CSR_DATA_PHASE_DONE]) begin
            data_end_q <= 1'b1;
        end else if (data_phase_clear || ctrl_end_seen) begin
            data_end_q <= 1'b0;
        end
    end

    a_data_end_set: assert property (@(posedge clock) disable iff (rst)
        (wr_csr && wdata[UFC_CSR_DATA_PHASE_DONE]) |=> data_end_q)
        else $error("data end not set by write");

    a_data_end_drop: assert property (@(posedge clock) disable iff (rst)
        ((data_phase_clear || ctrl_end_seen) && !(wr_csr && wdata[UFC_CSR_DATA_PHASE_DONE]))
        |=> !data_end_q)
        else $error("data end not cleared by hardware");

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            setup_end_q <= 1'b0;
        end else if (ctrl_end_seen && !data_end_q) begin
            setup_end_q <= 1'b1;
        end else if (wr_csr && wdata[UFC_CSR_SSETUP]) begin
            setup_end_q <= 1'b0;
        end
    end

    a_setup_end_hold: assert property (@(posedge clock) disable iff (rst)
        (setup_end_q && !(wr_csr && wdata[UFC_CSR_SSETUP])) |=> setup_end_q)
        else $error("setup end dropped without service");

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_ready_q <= 1'b0;
            rx_count_q <= '0;
        end else if (rx_packet_in) begin
            rx_ready_q <= 1'b1;
            rx_count_q <= rx_count_in;
        end else if (wr_csr && wdata[UFC_CSR_SRXRDY]) begin
            rx_ready_q <= 1'b0;
        end
    end

    a_rx_ready_set: assert property (@(posedge clock) disable iff (rst)
        rx_packet_in |=> rx_ready_q)
        else $error("rx ready not set on packet");

    a_rx_ready_clear: assert property (@(posedge clock) disable iff (rst)
        (wr_csr && wdata[UFC_CSR_SRXRDY] && !rx_packet_in) |=> !rx_ready_q)
        else $error("rx ready not cleared by service");

    a_rx_count_load: assert property (@(posedge clock) disable iff (rst)
        rx_packet_in |=> (rx_count_q == $past(rx_count_in)))
        else $error("rx count not captured");

    a_rx_count_hold: assert property (@(posedge clock) disable iff (rst)
        !rx_packet_in |=> $stable(rx_count_q))
        else $error("rx count changed without packet");

    // ------------------------------------------------------------
    // handshake gating per endpoint
    // ------------------------------------------------------------
    for (genvar e = 1; e <= 3; e++) begin : g_hs
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                hs_allow[e] <= 1'b0;
            end else begin
                hs_allow[e] <= hs_request[e] && ep_en_q[e];
            end
        end

        a_hs_grant: assert property (@(posedge clock) disable iff (rst)
            (hs_request[e] && ep_en_q[e]) |=> hs_allow[e])
            else $error("handshake withheld on enabled endpoint");

        a_hs_block: assert property (@(posedge clock) disable iff (rst)
            !ep_en_q[e] |=> !hs_allow[e])
            else $error("handshake given on disabled endpoint");
    end

    // ------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(cmn_flags_q & cmn_ie_q) | |(in_flags_q & in_ie_q)
                 | |(out_flags_q & out_ie_q);
        end
    end

    a_irq_idle: assert property (@(posedge clock) disable iff (rst)
        ((cmn_flags_q & cmn_ie_q) == 4'h0 && (in_flags_q & in_ie_q) == 4'h0
         && (out_flags_q & out_ie_q) == 3'h0) |=> !irq)
        else $error("irq without enabled flag");

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        unique case (index_q)
            UFC_ADDR_FLAGS:   rdata_d = {4'h0, cmn_flags_q};
            UFC_ADDR_IN_FLAGS: rdata_d = {4'h0, in_flags_q};
            UFC_ADDR_OUT_FLAGS: rdata_d = {4'h0, out_flags_q, 1'b0};
            UFC_ADDR_IN_IE:   rdata_d = {4'h0, in_ie_q};
            UFC_ADDR_OUT_IE:  rdata_d = {4'h0, out_ie_q, 1'b0};
            UFC_ADDR_CMN_IE:  rdata_d = {4'h0, cmn_ie_q};
            UFC_ADDR_EP0_CSR: rdata_d = {3'h0, setup_end_q, data_end_q, 2'h0,
                                         rx_ready_q};
            UFC_ADDR_EP0_CNT: rdata_d = {1'b0, rx_count_q};
            UFC_ADDR_EP_EN:   rdata_d = {4'h0, ep_en_q, 1'b1};
            default:          rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (data_rd) begin
            rdata <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_reset_flag_set: assert property (@(posedge clock) disable iff (rst)
        bus_reset_seen |=> cmn_flags_q[UFC_CF_RESET])
        else $error("bus reset flag not set");

    a_resume_gated: assert property (@(posedge clock) disable iff (rst)
        (!cmn_flags_q[UFC_CF_RESUME] && !(bus_resume_seen && suspended))
        |=> !cmn_flags_q[UFC_CF_RESUME])
        else $error("resume flag set while not suspended");

    a_suspend_gated: assert property (@(posedge clock) disable iff (rst)
        (bus_suspend_seen && !suspend_detect_enable && !cmn_flags_q[UFC_CF_SUSPEND])
        |=> !cmn_flags_q[UFC_CF_SUSPEND])
        else $error("suspend flag set while detection disabled");

    a_read_clears: assert property (@(posedge clock) disable iff (rst)
        (rd_flags && !bus_reset_seen && !frame_start_seen && !bus_resume_seen
         && !bus_suspend_seen) |=> cmn_flags_q == 4'h0)
        else $error("common flags not cleared by read");

    a_setup_end_clear: assert property (@(posedge clock) disable iff (rst)
        (wr_csr && wdata[UFC_CSR_SSETUP] && !ctrl_end_seen) |=> !setup_end_q)
        else $error("setup end not cleared");

    a_setup_end_set: assert property (@(posedge clock) disable iff (rst)
        (ctrl_end_seen && !data_end_q) |=> setup_end_q)
        else $error("setup end not set");

    a_rx_ready_hold: assert property (@(posedge clock) disable iff (rst)
        (rx_ready_q && !(wr_csr && wdata[UFC_CSR_SRXRDY])) |=> rx_ready_q)
        else $error("rx ready dropped without service");

    a_ep_disabled: assert property (@(posedge clock) disable iff (rst)
        !ep_en_q[1] |=> !hs_allow[1])
        else $error("handshake on disabled endpoint");

    a_irq_enable: assert property (@(posedge clock) disable iff (rst)
        (cmn_flags_q[UFC_CF_RESET] && cmn_ie_q[UFC_CF_RESET]) |=> irq)
        else $error("irq missing for enabled flag");

endmodule : ufc_core

`default_nettype wire

// ---- sim/ufc_host_model.sv ----
// host side model: turns bench requests into one-cycle bus event pulses
// assumes requests change just after a rising clock edge
`timescale 1ns/10ps
`default_nettype none

module ufc_host_model (
    input  wire logic       clock,
    input  wire logic       go,
    input  wire logic [2:0] kind,
    input  wire logic [6:0] count,
    output logic      [5:0] ev_q,
    output logic      [6:0] cnt_q
);
    // ------------------------------------------------------------
    // event pulses: 0 reset, 1 resume, 2 suspend, 3 frame start,
    // 4 control end, 5 packet received
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        ev_q <= go ? 6'(1 << kind) : 6'h00;
    end

    // count is shown with the packet, then inverted again on every following cycle
    always_ff @(posedge clock) begin
        cnt_q <= (go && kind == 3'd5) ? count : ~cnt_q;
    end
endmodule : ufc_host_model

`default_nettype wire

// ---- sim/tb_top.sv ----
// testbench for the usb function interrupt and endpoint 0 block
// assumes the host model of ufc_host_model.sv and the design package
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import ufc_pkg::*;
    logic       clock, rst, idx_wr, data_wr, data_rd, go, sde, dpc, suspended, irq;
    logic [3:0] in_ev;
    logic [7:0] wdata, rdata;
    logic [2:0] kind;
    logic [6:0] cnt, rx_cnt;
    logic [5:0] ev;
    logic [3:1] hs_req, hs_allow, out_ev;
    int         n_errors, n_compared;

    always #5 clock = ~clock;

    ufc_host_model host_u (.clock(clock), .go(go), .kind(kind), .count(cnt),
                           .ev_q(ev), .cnt_q(rx_cnt));
    ufc_core dut_u (.clock(clock), .rst(rst), .idx_wr(idx_wr), .data_wr(data_wr),
        .data_rd(data_rd), .wdata(wdata), .rdata(rdata), .suspend_detect_enable(sde),
        .bus_reset_seen(ev[0]), .bus_resume_seen(ev[1]), .bus_suspend_seen(ev[2]),
        .frame_start_seen(ev[3]), .ctrl_end_seen(ev[4]), .data_phase_clear(dpc),
        .rx_packet_in(ev[5]), .rx_count_in(rx_cnt), .in_ep_event(in_ev),
        .out_ep_event(out_ev), .hs_request(hs_req), .hs_allow(hs_allow),
        .suspended(suspended), .irq(irq));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
        @(posedge clock);
        idx_wr <= 1'b1;
        wdata  <= idx;
        @(posedge clock);
        idx_wr  <= 1'b0;
        data_wr <= 1'b1;
        wdata   <= val;
        @(posedge clock);
        data_wr <= 1'b0;
    endtask : reg_wr

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        @(posedge clock);
        idx_wr <= 1'b1;
        wdata  <= idx;
        @(posedge clock);
        idx_wr  <= 1'b0;
        data_rd <= 1'b1;
        @(posedge clock);
        data_rd <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask : rd_chk

    task automatic bus_ev(input logic [2:0] k);
        @(posedge clock);
        go   <= 1'b1;
        kind <= k;
        @(posedge clock);
        go <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask : bus_ev

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values;
        rd_chk("in_ie", UFC_ADDR_IN_IE, 8'h0F);
        rd_chk("out_ie", UFC_ADDR_OUT_IE, 8'h0E);
        rd_chk("cmn_ie", UFC_ADDR_CMN_IE, 8'h06);
        rd_chk("ep_en", UFC_ADDR_EP_EN, 8'h0F);
        rd_chk("csr", UFC_ADDR_EP0_CSR, 8'h00);
        rd_chk("count", UFC_ADDR_EP0_CNT, 8'h00);
        chk("hs_allow", 8'h0E, {4'h0, hs_allow, 1'b0});
    endtask : t_reset_values

    task automatic t_enables;
        reg_wr(UFC_ADDR_IN_IE, 8'hF5);
        rd_chk("in_ie w", UFC_ADDR_IN_IE, 8'h05);
        reg_wr(UFC_ADDR_OUT_IE, 8'hF5);
        rd_chk("out_ie w", UFC_ADDR_OUT_IE, 8'h04);
        reg_wr(UFC_ADDR_CMN_IE, 8'hF9);
        rd_chk("cmn_ie w", UFC_ADDR_CMN_IE, 8'h09);
        reg_wr(UFC_ADDR_IN_IE, 8'h0F);
        reg_wr(UFC_ADDR_OUT_IE, 8'h0E);
        reg_wr(UFC_ADDR_CMN_IE, 8'h06);
        rd_chk("cmn_ie back", UFC_ADDR_CMN_IE, 8'h06);
        reg_wr(8'h30, 8'hFF);
        rd_chk("unmapped", 8'h30, 8'h00);
        reg_wr(UFC_ADDR_EP_EN, 8'hF0);
        rd_chk("ep_en off", UFC_ADDR_EP_EN, 8'h01);
        chk("hs off", 8'h00, {5'h00, hs_allow});
        reg_wr(UFC_ADDR_EP_EN, 8'h0A);
        repeat (2) @(posedge clock);
        #1 chk("hs part", 8'h05, {5'h00, hs_allow});
        @(posedge clock);
        hs_req <= 3'b110;
        repeat (2) @(posedge clock);
        #1 chk("hs req", 8'h04, {5'h00, hs_allow});
        @(posedge clock);
        hs_req <= 3'b111;
        reg_wr(UFC_ADDR_EP_EN, 8'h0F);
    endtask : t_enables

    task automatic t_common;
        bus_ev(3'd2);
        chk("susp ignored", 8'h00, {7'h00, suspended});
        rd_chk("flags none", UFC_ADDR_FLAGS, 8'h00);
        @(posedge clock);
        sde <= 1'b1;
        bus_ev(3'd2);
        chk("susp entered", 8'h01, {7'h00, suspended});
        bus_ev(3'd1);
        rd_chk("flags sr", UFC_ADDR_FLAGS, 8'h03);
        rd_chk("flags clr", UFC_ADDR_FLAGS, 8'h00);
        bus_ev(3'd1);
        rd_chk("resume awake", UFC_ADDR_FLAGS, 8'h00);
        bus_ev(3'd3);
        chk("irq sof masked", 8'h00, {7'h00, irq});
        bus_ev(3'd0);
        chk("irq reset", 8'h01, {7'h00, irq});
        rd_chk("flags rf", UFC_ADDR_FLAGS, 8'h0C);
        repeat (2) @(posedge clock);
        #1 chk("irq gone", 8'h00, {7'h00, irq});
    endtask : t_common

    task automatic t_ep_flags;
        reg_wr(UFC_ADDR_IN_IE, 8'h0D);
        @(posedge clock);
        in_ev <= 4'h2;
        @(posedge clock);
        in_ev <= 4'h0;
        repeat (2) @(posedge clock);
        #1 chk("irq in masked", 8'h00, {7'h00, irq});
        rd_chk("in flags", UFC_ADDR_IN_FLAGS, 8'h02);
        reg_wr(UFC_ADDR_IN_IE, 8'h0F);
        @(posedge clock);
        out_ev <= 3'b100;
        @(posedge clock);
        out_ev <= 3'h0;
        repeat (2) @(posedge clock);
        #1 chk("irq out", 8'h01, {7'h00, irq});
        rd_chk("out flags", UFC_ADDR_OUT_FLAGS, 8'h08);
        repeat (2) @(posedge clock);
        #1 chk("irq out gone", 8'h00, {7'h00, irq});
    endtask : t_ep_flags

    task automatic t_ep0;
        @(posedge clock);
        cnt <= 7'h55;
        bus_ev(3'd5);
        rd_chk("rx ready", UFC_ADDR_EP0_CSR, 8'h01);
        rd_chk("rx count", UFC_ADDR_EP0_CNT, 8'h55);
        reg_wr(UFC_ADDR_EP0_CSR, 8'h40);
        rd_chk("rx served", UFC_ADDR_EP0_CSR, 8'h00);
        rd_chk("ep0 flag", UFC_ADDR_IN_FLAGS, 8'h01);
        bus_ev(3'd4);
        rd_chk("setup end", UFC_ADDR_EP0_CSR, 8'h10);
        reg_wr(UFC_ADDR_EP0_CSR, 8'h80);
        rd_chk("setup served", UFC_ADDR_EP0_CSR, 8'h00);
        reg_wr(UFC_ADDR_EP0_CSR, 8'h08);
        rd_chk("data end", UFC_ADDR_EP0_CSR, 8'h08);
        bus_ev(3'd4);
        rd_chk("no setup end", UFC_ADDR_EP0_CSR, 8'h00);
        reg_wr(UFC_ADDR_EP0_CSR, 8'h08);
        @(posedge clock);
        dpc <= 1'b1;
        @(posedge clock);
        dpc <= 1'b0;
        rd_chk("data end hw", UFC_ADDR_EP0_CSR, 8'h00);
    endtask : t_ep0

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        end_sim();
    end

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        {idx_wr, data_wr, data_rd, go, sde, dpc} = 6'h00;
        in_ev = 4'h0;
        out_ev = 3'h0;
        wdata = 8'h00;
        kind = 3'd0;
        cnt = 7'h00;
        hs_req = 3'b111;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_reset_values();
        t_enables();
        t_common();
        t_ep_flags();
        t_ep0();
        end_sim();
    end
endmodule : tb_top

`default_nettype wire
